// >>> src/rtcs_core.sv
// Serial-access clock: unlock matcher, bit transfer, BCD clock registers.
// Assumes host strobes, select and abort are synchronous to clk.
`timescale 1ns/1ps
module rtcs_core import rtcs_pkg::*; #(
   parameter int unsigned TICKS = TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic select_in_n,
   input  wire logic read_en_n,
   input  wire logic write_en_n,
   input  wire logic data_in,
   input  wire logic abort_n,
   output logic      data_out,
   output logic      data_out_en,
   output logic      memory_select_out_n
);
   if (TICKS < 2) begin : g_ticks_check
      $error("TICKS must be at least 2");
   end

   logic [7:0]  regs_q [8];
   rtcs_state_e state_q, state_d;
   logic [5:0]  ptr_q;
   logic [5:0]  cnt_q;
   logic        rd_prev_q, wr_prev_q, last_d_q;
   logic [7:0]  sh_q;
   logic [31:0] pre_q;
   logic        tick;
   logic        rd_act, wr_act, rd_end, wr_end, abort_hit, cur_bit;
   logic [10:0] fifo_q [2];
   logic        wp_q, rp_q;
   logic [1:0]  fcnt_q;
   logic        push, pop, in_ready, out_valid, out_ready;
   logic [7:0]  byte_in;
   logic        data_out_q, data_oe_q, msel_q;
   logic [63:0] snap_q;

   assign rd_act    = !select_in_n && !read_en_n && write_en_n;
   assign wr_act    = !select_in_n && !write_en_n;
   assign rd_end    = rd_prev_q && !rd_act;
   assign wr_end    = wr_prev_q && !wr_act;
   // The abort pin is gated only by the day abort-ignore bit, never qualified by select or strobes.
   assign abort_hit = !abort_n && !regs_q[REG_DAY][DAY_ABT_BIT];
   assign cur_bit   = snap_q[cnt_q];
   assign byte_in   = {last_d_q, sh_q[7:1]};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         last_d_q  <= 1'b0;
      end else begin
         rd_prev_q <= rd_act;
         wr_prev_q <= wr_act;
         if (wr_act)
            last_d_q <= data_in;
      end
   end

   always_comb begin
      state_d = state_q;
      if (abort_hit)
         state_d = ST_DEAD;
      else case (state_q)
         ST_DEAD: begin
            if (rd_end)
               state_d = ST_MATCH;
         end
         ST_MATCH: begin
            if (rd_end)
               state_d = ST_MATCH;
            else if (wr_end && last_d_q != UNLOCK_PAT[ptr_q])
               state_d = ST_DEAD;
            else if (wr_end && ptr_q == 6'(NUM_BITS - 1))
               state_d = ST_XFER;
         end
         ST_XFER: begin
            if ((rd_end || wr_end) && cnt_q == 6'(NUM_BITS - 1))
               state_d = ST_DEAD;
         end
         default: state_d = ST_DEAD;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_DEAD;
         ptr_q   <= 6'h00;
         cnt_q   <= 6'h00;
         sh_q    <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_d != ST_MATCH || (state_q == ST_MATCH && rd_end))
            ptr_q <= 6'h00;
         else if (state_q == ST_MATCH && wr_end)
            ptr_q <= ptr_q + 6'h01;
         if (state_q != ST_XFER || state_d != ST_XFER)
            cnt_q <= 6'h00;
         else if (rd_end || wr_end)
            cnt_q <= cnt_q + 6'h01;
         if (state_q == ST_XFER && wr_end && !abort_hit)
            sh_q <= byte_in;
      end
   end

   // Whole bytes only reach the registers; an abort drops a partial byte.
   assign push = state_q == ST_XFER && wr_end && !abort_hit
                 && cnt_q[2:0] == 3'h7 && in_ready;
   assign in_ready  = fcnt_q != 2'h2;
   assign out_valid = fcnt_q != 2'h0;
   // The clock update owns the registers on a tick; the buffer waits.
   assign out_ready = !tick;
   assign pop       = out_valid && out_ready && !abort_hit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q   <= 1'b0;
         rp_q   <= 1'b0;
         fcnt_q <= 2'h0;
         fifo_q <= '{default: 11'h000};
      end else if (abort_hit) begin
         // An abort drops queued bytes too; bytes of a cut stream already popped stay written.
         wp_q   <= 1'b0;
         rp_q   <= 1'b0;
         fcnt_q <= 2'h0;
      end else begin
         if (push) begin
            fifo_q[wp_q] <= {cnt_q[5:3], byte_in};
            wp_q         <= !wp_q;
         end
         if (pop)
            rp_q <= !rp_q;
         fcnt_q <= fcnt_q + 2'(push) - 2'(pop);
      end
   end

   // TICKS is cut short only in simulation; the default gives a 10 ms step.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 32'h0;
         tick  <= 1'b0;
      end else if (regs_q[REG_DAY][DAY_OSC_BIT]) begin
         pre_q <= 32'h0;
         tick  <= 1'b0;
      end else begin
         tick  <= pre_q == 32'(TICKS - 1);
         pre_q <= (pre_q == 32'(TICKS - 1)) ? 32'h0 : pre_q + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      logic [8:0] r;
      logic       c;
      logic [7:0] h;
      r = 9'h000;
      c = 1'b0;
      h = 8'h00;
      if (!rst_n) begin
         for (int i = 0; i < 8; i++)
            regs_q[i] <= RESET_VAL[i*8 +: 8];
      end else if (tick) begin
         r = rtcs_bcd_inc(regs_q[REG_HUND], BCD_00, BCD_99);
         regs_q[REG_HUND] <= r[7:0];
         c = r[8];
         if (c) begin
            r = rtcs_bcd_inc(regs_q[REG_SEC], BCD_00, BCD_59);
            regs_q[REG_SEC] <= r[7:0];
            c = r[8];
         end
         if (c) begin
            r = rtcs_bcd_inc(regs_q[REG_MIN], BCD_00, BCD_59);
            regs_q[REG_MIN] <= r[7:0];
            c = r[8];
         end
         if (c) begin
            h = regs_q[REG_HOUR];
            if (h[HOUR_FMT_BIT]) begin
               r = rtcs_bcd_inc({3'h0, h[4:0]}, BCD_01, BCD_12);
               c = h[4:0] == BCD_11[4:0] && h[HOUR_PM_BIT];
               h[HOUR_PM_BIT] = h[HOUR_PM_BIT] ^ (h[4:0] == BCD_11[4:0]);
               h[4:0] = r[4:0];
            end else begin
               r = rtcs_bcd_inc({2'h0, h[5:0]}, BCD_00, BCD_23);
               c = r[8];
               h[5:0] = r[5:0];
            end
            regs_q[REG_HOUR] <= h & USED_MASK[REG_HOUR*8 +: 8];
         end
         if (c) begin
            r = rtcs_bcd_inc({5'h0, regs_q[REG_DAY][2:0]}, BCD_01, BCD_07);
            regs_q[REG_DAY] <= {regs_q[REG_DAY][7:3], r[2:0]};
            r = rtcs_bcd_inc(regs_q[REG_DATE], BCD_01,
                             rtcs_last_day(regs_q[REG_MONTH], regs_q[REG_YEAR]));
            regs_q[REG_DATE] <= r[7:0];
            c = r[8];
         end
         if (c) begin
            r = rtcs_bcd_inc(regs_q[REG_MONTH], BCD_01, BCD_12);
            regs_q[REG_MONTH] <= r[7:0];
            c = r[8];
         end
         if (c) begin
            r = rtcs_bcd_inc(regs_q[REG_YEAR], BCD_00, BCD_99);
            regs_q[REG_YEAR] <= r[7:0];
         end
      end else if (pop) begin
         regs_q[fifo_q[rp_q][10:8]] <= fifo_q[rp_q][7:0]
            & USED_MASK[fifo_q[rp_q][10:8]*8 +: 8];
      end
   end

   // A read returns the time as it stood when access opened, so a tick in
   // mid-transfer cannot tear a BCD digit across two values.
   // A read that follows writes in the same transfer still sees the old image.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_q <= RESET_VAL;
      end else if (state_q != ST_XFER) begin
         for (int i = 0; i < 8; i++)
            snap_q[i*8 +: 8] <= regs_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out_q <= 1'b0;
         data_oe_q  <= 1'b0;
         msel_q     <= 1'b1;
      end else begin
         data_out_q <= cur_bit;
         data_oe_q  <= state_q == ST_XFER && !abort_hit && rd_act;
         // Memory is shut out for the whole transfer, not only on our strobes.
         msel_q     <= (state_d == ST_XFER) ? 1'b1 : select_in_n;
      end
   end

   assign data_out            = data_out_q;
   assign data_out_en         = data_oe_q;
   assign memory_select_out_n = msel_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   mem_select_hold_a: assert property (state_q == ST_XFER |-> memory_select_out_n)
      else $error("memory select low during transfer");
   abort_stops_a: assert property (abort_hit |=> state_q == ST_DEAD && cnt_q == 6'h00)
      else $error("abort did not end transfer");
   abort_ignored_a: assert property (!abort_n && regs_q[REG_DAY][DAY_ABT_BIT]
      && state_q == ST_XFER && !rd_end && !wr_end |=> state_q == ST_XFER)
      else $error("abort acted while disabled");
   read_restart_a: assert property (state_q == ST_MATCH && rd_end && !abort_hit
      |=> state_q == ST_MATCH && ptr_q == 6'h00)
      else $error("read did not restart matching");
   mismatch_lock_a: assert property (state_q == ST_MATCH && wr_end && !abort_hit
      && last_d_q != UNLOCK_PAT[ptr_q] |=> state_q == ST_DEAD)
      else $error("mismatch did not stop matching");
   unlock_open_a: assert property (state_q == ST_MATCH && wr_end && !abort_hit
      && ptr_q == 6'h3f && last_d_q == UNLOCK_PAT[63]
      |=> state_q == ST_XFER && cnt_q == 6'h00)
      else $error("full match did not open access");
   zero_bits_a: assert property ((regs_q[REG_HOUR] & ~USED_MASK[31:24]) == 8'h00
      && (regs_q[REG_DAY] & ~USED_MASK[39:32]) == 8'h00)
      else $error("unused bit reads one");
   frozen_clock_a: assert property (regs_q[REG_DAY][DAY_OSC_BIT] && !tick && !pop
      |=> $stable(regs_q[REG_HUND]))
      else $error("clock advanced while stopped");
   read_bit_a: assert property (state_q == ST_XFER && rd_act && !abort_hit
      |=> data_out_en && data_out == $past(cur_bit))
      else $error("wrong bit driven");
   bcd_digits_a: assert property (regs_q[REG_HUND][3:0] <= 4'h9
      && regs_q[REG_HUND][7:4] <= 4'h9)
      else $error("hundredths not BCD");

   // The checks below watch transfer framing, the buffer, the snapshot, the match pointer and the hour format.
   msel_follow_a: assert property (state_q != ST_XFER && state_d != ST_XFER
      |=> memory_select_out_n == $past(select_in_n))
      else $error("memory select does not follow select input");
   out_idle_a: assert property (!rd_act |=> !data_out_en)
      else $error("data driven without a read");
   oe_in_xfer_a: assert property (data_out_en |-> $past(state_q) == ST_XFER)
      else $error("data driven outside a transfer");
   xfer_close_a: assert property (state_q == ST_XFER && (rd_end || wr_end)
      && cnt_q == 6'h3f |=> state_q == ST_DEAD)
      else $error("transfer did not close after 64 cycles");
   abort_flush_a: assert property (abort_hit |=> fcnt_q == 2'h0)
      else $error("abort left queued bytes");
   snap_hold_a: assert property (state_q == ST_XFER
      |=> state_q != ST_XFER || $stable(snap_q))
      else $error("snapshot changed inside a transfer");
   ptr_idle_a: assert property (state_q == ST_DEAD |-> ptr_q == 6'h00)
      else $error("match pointer not at first bit while locked");
   hour_format_a: assert property (tick && regs_q[REG_HOUR][HOUR_FMT_BIT]
      |=> regs_q[REG_HOUR][HOUR_FMT_BIT])
      else $error("hour format changed on a tick");

   unlock_seen_c: cover property (state_q == ST_MATCH ##1 state_q == ST_XFER);
   byte_written_c: cover property (pop);
   abort_xfer_c: cover property (state_q == ST_XFER && abort_hit);
   hour_roll_c: cover property (tick && regs_q[REG_HOUR][HOUR_FMT_BIT] && regs_q[REG_MIN] == BCD_59);
   abort_ignore_c: cover property (!abort_n && regs_q[REG_DAY][DAY_ABT_BIT] && state_q == ST_XFER);
endmodule

// >>> src/rtcs_pkg.sv
// Constants, types and helpers for the serial clock register port.
// Assumes one 20 MHz clock with host strobes already synchronous to it.
// Summary of operation
// - Eight 8-bit registers, moved one bit per cycle, only after unlock.
// - All timekeeping register values are binary coded decimal.
// - Transfers run bit 0 of register 0 through bit 7 of register 7.
// - Hours bit 7 high selects 12-hour counting, low selects 24-hour.
// - Hours bit 5 is afternoon in 12-hour mode, tens-of-twenty in 24-hour.
// - Day bit 4 high makes the device ignore the abort pin.
// - Day bit 4 low: abort low ends any transfer, registers kept.
// - Abort acts whatever select and strobe inputs are doing.
// - Day bit 5 written zero starts the oscillator and counting.
// - Registers 1 to 6 hold unused bits that always read zero.
// - Writes to unused bits accept any value; they still read zero.
// - A read resets the pointer; 64 writes must match the unlock pattern.
// - Any read during matching restarts matching at the first bit.
// - After unlock, 64 cycles shift data in on writes, out on reads.
// - Memory select follows select input while locked, high during transfer.
package rtcs_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned TICK_HZ     = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int unsigned NUM_BITS    = 64;
   localparam logic [63:0] UNLOCK_PAT  = 64'h5ca33ac55ca33ac5;
   localparam logic [2:0]  REG_HUND    = 3'h0;
   localparam logic [2:0]  REG_SEC     = 3'h1;
   localparam logic [2:0]  REG_MIN     = 3'h2;
   localparam logic [2:0]  REG_HOUR    = 3'h3;
   localparam logic [2:0]  REG_DAY     = 3'h4;
   localparam logic [2:0]  REG_DATE    = 3'h5;
   localparam logic [2:0]  REG_MONTH   = 3'h6;
   localparam logic [2:0]  REG_YEAR    = 3'h7;
   localparam int unsigned HOUR_FMT_BIT = 7;
   localparam int unsigned HOUR_PM_BIT  = 5;
   localparam int unsigned DAY_ABT_BIT  = 4;
   localparam int unsigned DAY_OSC_BIT  = 5;
   localparam logic [63:0] USED_MASK   = 64'hff_1f_3f_37_bf_7f_7f_ff;
   localparam logic [63:0] RESET_VAL   = 64'h00_01_01_21_00_00_00_00;
   localparam logic [7:0]  BCD_59 = 8'h59;
   localparam logic [7:0]  BCD_99 = 8'h99;
   localparam logic [7:0]  BCD_23 = 8'h23;
   localparam logic [7:0]  BCD_12 = 8'h12;
   localparam logic [7:0]  BCD_11 = 8'h11;
   localparam logic [7:0]  BCD_07 = 8'h07;
   localparam logic [7:0]  BCD_01 = 8'h01;
   localparam logic [7:0]  BCD_02 = 8'h02;
   localparam logic [7:0]  BCD_00 = 8'h00;

   typedef enum logic [1:0] {ST_DEAD, ST_MATCH, ST_XFER} rtcs_state_e;

   // Returns {carry, next}; wraps to lo after hi.
   function automatic logic [8:0] rtcs_bcd_inc(input logic [7:0] v,
                                                input logic [7:0] lo,
                                                input logic [7:0] hi);
      if (v >= hi)
         return {1'b1, lo};
      else if (v[3:0] == 4'h9)
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         return {1'b0, v + 8'h01};
   endfunction

   function automatic logic [7:0] rtcs_last_day(input logic [7:0] mon,
                                                input logic [7:0] yr);
      logic leap;
      leap = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00));
      case (mon)
         BCD_02:                         return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11:     return 8'h30;
         default:                        return 8'h31;
      endcase
   endfunction
endpackage

// >>> sim/rtcs_host.sv
// Host processor model: drives select and strobes one bit cycle at a time.
// Assumes the clock register port is on the far side and clk is shared.
`timescale 1ns/1ps
module rtcs_host import rtcs_pkg::*; (
   input  wire logic clk,
   input  wire logic data_out,
   input  wire logic data_out_en,
   input  wire logic memory_select_out_n,
   output logic      select_in_n,
   output logic      read_en_n,
   output logic      write_en_n,
   output logic      data_in,
   output logic      abort_n
);
   initial begin
      select_in_n = 1'b1;
      read_en_n   = 1'b1;
      write_en_n  = 1'b1;
      data_in     = 1'b0;
      abort_n     = 1'b1;
   end

   // One access cycle, then strobes high; seen is {memory select, enable, data}.
   // The data line flips when released so a stale value is never read as held.
   task automatic cyc(input logic is_wr, input logic b, output logic [2:0] seen);
      @(posedge clk);
      select_in_n <= 1'b0;
      if (is_wr) begin
         write_en_n <= 1'b0;
         data_in    <= b;
      end else begin
         read_en_n <= 1'b0;
      end
      @(posedge clk);
      select_in_n <= 1'b1;
      write_en_n  <= 1'b1;
      read_en_n   <= 1'b1;
      data_in     <= ~b;
      #1;
      seen = {memory_select_out_n, data_out_en, data_out};
   endtask

   // A read first rewinds the matcher, then the pattern goes out lsb first.
   task automatic unlock;
      logic [2:0] s;
      cyc(1'b0, 1'b0, s);
      for (int i = 0; i < 64; i++) cyc(1'b1, UNLOCK_PAT[i], s);
   endtask

   // Reads bits lo..hi of the stream; ok drops if enable or memory select falls.
   task automatic rd_bits(input int lo, input int hi, inout logic [63:0] v, inout logic ok);
      logic [2:0] s;
      for (int i = lo; i <= hi; i++) begin
         cyc(1'b0, 1'b0, s);
         v[i] = s[0];
         ok   = ok & s[1] & s[2];
      end
   endtask

   // Whole stream, whole bytes, register 0 bit 0 first.
   task automatic wr_all(input logic [63:0] v);
      logic [2:0] s;
      for (int i = 0; i < 64; i++) cyc(1'b1, v[i], s);
   endtask

   // Abort pulse, optionally on top of an active read cycle.
   task automatic abort_pulse(input logic with_cycle);
      @(posedge clk);
      abort_n <= 1'b0;
      if (with_cycle) begin
         select_in_n <= 1'b0;
         read_en_n   <= 1'b0;
      end
      @(posedge clk);
      abort_n     <= 1'b1;
      select_in_n <= 1'b1;
      read_en_n   <= 1'b1;
   endtask
endmodule

// >>> sim/rtcs_core_bench.sv
// Self-checking bench for the serial clock register port.
// Assumes the host model drives all strobes; tick count shortened to 4.
`timescale 1ns/1ps
module rtcs_core_bench import rtcs_pkg::*;;
   localparam int unsigned TK = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sel_n, rd_n, wr_n, din, abt_n, dout, dout_en, mso_n;
   int num_errors = 0;
   int n_tests = 0;
   // Fields written with every unused bit set but day bits 7:6; day keeps oscillator stopped.
   localparam logic [63:0] W_FROZEN = 64'h24_e9_e8_2f_f1_d8_d9_12;
   // Same image with the abort pin ignored and the oscillator stopped.
   localparam logic [63:0] W_IGNORE = {W_FROZEN[63:40], 8'h37, W_FROZEN[31:0]};

   always #25 clk = ~clk;

   rtcs_core #(.TICKS(TK)) u_dut (
      .clk(clk), .rst_n(rst_n), .select_in_n(sel_n), .read_en_n(rd_n),
      .write_en_n(wr_n), .data_in(din), .abort_n(abt_n), .data_out(dout),
      .data_out_en(dout_en), .memory_select_out_n(mso_n));

   rtcs_host u_host (
      .clk(clk), .data_out(dout), .data_out_en(dout_en),
      .memory_select_out_n(mso_n), .select_in_n(sel_n), .read_en_n(rd_n),
      .write_en_n(wr_n), .data_in(din), .abort_n(abt_n));

   task automatic chk1(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk64(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic read_all(output logic [63:0] v, output logic ok);
      ok = 1'b1;
      u_host.unlock();
      u_host.rd_bits(0, 63, v, ok);
   endtask

   task automatic t_reset;
      logic [63:0] v;
      logic ok;
      chk1("mem select idle", 1'b1, mso_n);
      chk1("out enable idle", 1'b0, dout_en);
      read_all(v, ok);
      chk64("reset image", RESET_VAL, v);
      chk1("transfer framing", 1'b1, ok);
      $display("test reset values done");
   endtask

   task automatic t_fields;
      logic [63:0] v1, v2;
      logic ok;
      u_host.unlock();
      u_host.wr_all(W_FROZEN);
      read_all(v1, ok);
      chk64("masked fields", W_FROZEN & USED_MASK, v1);
      read_all(v2, ok);
      chk64("frozen clock", v1, v2);
      $display("test fields done");
   endtask

   task automatic t_run;
      logic [63:0] v;
      logic ok;
      u_host.unlock();
      u_host.wr_all({W_FROZEN[63:40], 8'h07, W_FROZEN[31:0]});
      repeat (40) @(posedge clk);
      read_all(v, ok);
      chk1("hundredths moved", 1'b1, v[7:0] !== 8'h12);
      chk1("bcd digit", 1'b1, v[3:0] <= 4'h9 && v[11:8] <= 4'h9);
      $display("test oscillator done");
   endtask

   task automatic t_abort;
      logic [63:0] v;
      logic [2:0] s;
      logic ok;
      ok = 1'b1;
      u_host.unlock();
      u_host.rd_bits(0, 9, v, ok);
      u_host.abort_pulse(1'b1);
      u_host.cyc(1'b0, 1'b0, s);
      chk1("locked after abort", 1'b0, s[1]);
      chk1("mem select follows", 1'b0, s[2]);
      // The first pass stops the clock, so the second lands with no tick.
      u_host.unlock();
      u_host.wr_all(W_IGNORE);
      u_host.unlock();
      u_host.wr_all(W_IGNORE);
      u_host.unlock();
      u_host.rd_bits(0, 9, v, ok);
      u_host.abort_pulse(1'b0);
      u_host.rd_bits(10, 63, v, ok);
      chk64("abort ignored", W_IGNORE & USED_MASK, v);
      chk1("ignored framing", 1'b1, ok);
      $display("test abort done");
   endtask

   task automatic t_lock;
      logic [2:0] s;
      logic [63:0] v;
      logic ok;
      u_host.cyc(1'b0, 1'b0, s);
      u_host.cyc(1'b1, ~UNLOCK_PAT[0], s);
      for (int i = 1; i < 64; i++) u_host.cyc(1'b1, UNLOCK_PAT[i], s);
      u_host.cyc(1'b0, 1'b0, s);
      chk1("mismatch stays locked", 1'b0, s[1]);
      for (int i = 0; i < 32; i++) u_host.cyc(1'b1, UNLOCK_PAT[i], s);
      read_all(v, ok);
      chk1("restart after read", 1'b1, ok);
      $display("test lock done");
   endtask

   // Lower fields sit at their top so the first tick rolls the hour.
   // The first pass stops the clock, so no tick comes until the second pass writes the day byte.
   task automatic t_roll(input logic [7:0] hr, input logic [7:0] hr_exp,
                         input logic [7:0] wd_exp);
      logic [63:0] v;
      logic ok;
      u_host.unlock();
      u_host.wr_all({24'h24_06_15, 8'h37, hr, 24'h59_59_99});
      u_host.unlock();
      u_host.wr_all({24'h24_06_15, 8'h17, hr, 24'h59_59_99});
      read_all(v, ok);
      chk8("hours after roll", hr_exp, v[31:24]);
      chk8("weekday after roll", wd_exp, {5'h0, v[34:32]});
      chk1("roll framing", 1'b1, ok);
      $display("test rollover done");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_fields();
      t_run();
      t_abort();
      t_lock();
      t_roll(8'hb1, 8'h92, 8'h01);
      t_roll(8'h19, 8'h20, 8'h07);
      report_and_stop();
   end

   // The tests need about 4500 cycles; four times that means a hang.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule
